/* File: rtl/dcr_device_setup.sv */
// device setup register bank with sleep timer, duty divider and host watchdog
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "dcr_cfg.svh"

module dcr_device_setup #(
	parameter int SLEEP_CYC0 = (`DCR_SLEEP_T0_US * 1000 + `DCR_CLK_PERIOD_NS - 1)
		/ `DCR_CLK_PERIOD_NS,
	parameter int SLEEP_CYC1 = (`DCR_SLEEP_T1_US * 1000 + `DCR_CLK_PERIOD_NS - 1)
		/ `DCR_CLK_PERIOD_NS,
	parameter int SLEEP_CYC2 = (`DCR_SLEEP_T2_MS * 1000000 + `DCR_CLK_PERIOD_NS - 1)
		/ `DCR_CLK_PERIOD_NS,
	parameter int SLEEP_CYC3 = (`DCR_SLEEP_T3_MS * 1000000 + `DCR_CLK_PERIOD_NS - 1)
		/ `DCR_CLK_PERIOD_NS,
	parameter int MS_CYC     = 1000000 / `DCR_CLK_PERIOD_NS
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [9:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// straps and status from the rest of the device
	input  wire logic [6:0]  target_addr_strap,
	input  wire logic [1:0]  input_ref_mode,
	input  wire logic        freq_meas_valid,
	input  wire logic [14:0] freq_meas,
	input  wire logic        rate_below_threshold,
	input  wire logic [1:0]  current_level,
	input  wire logic [1:0]  voltage_level,
	input  wire logic        wdt_bus_tickle,
	input  wire logic        wdt_pin_tickle,
	// monitor pin
	output logic             analog_monitor_output_en,
	output logic      [3:0]  shared_pin_route,
	// serial pins and supply
	output logic      [6:0]  serial_target_addr,
	output logic      [1:0]  serial_pin_drive,
	output logic             pullup_en,
	output logic      [1:0]  max_supply_range_sel,
	output logic             supply_range_reserved,
	// rate command
	output logic      [15:0] duty_cmd,
	output logic             duty_cmd_valid,
	output logic             lowpower_req,
	output logic             lowpower_state_select,
	// gains and clock
	output logic      [1:0]  current_gain_sel,
	output logic      [1:0]  voltage_gain_sel,
	output logic             use_external_clock,
	output logic             clock_select_reserved,
	output logic             external_reference_mode_on,
	output logic      [2:0]  external_reference_freq_sel,
	// watchdog and interrupt
	output logic             wdt_fault_report,
	output logic             wdt_fault_latched,
	output logic             outputs_hiz,
	output logic             irq
);
	dcr_pkg::dcr_one_t      one_q;
	dcr_pkg::dcr_two_t      two_q;
	dcr_pkg::dcr_div_state_t div_q;
	logic        strap_done_q;
	logic [1:0]  stat_q;
	logic [1:0]  mask_q;
	logic [31:0] prdata_q;
	logic        pslverr_q;
	logic [24:0] sleep_cnt_q;
	logic        lowpower_q;
	logic [15:0] rem_q;
	logic [14:0] quo_q;
	logic [3:0]  step_q;
	logic [15:0] duty_q;
	logic        duty_vld_q;
	logic [1:0]  cgain_q;
	logic [1:0]  vgain_q;
	logic        pin_prev_q;
	logic [16:0] ms_pre_q;
	logic [13:0] ms_cnt_q;
	logic        wdt_latch_q;
	logic        wdt_rep_q;
	logic        setup;
	logic        wr;
	logic        hit_one;
	logic        hit_two;
	logic        hit_stat;
	logic        hit_mask;
	logic        hit_state;
	logic        mapped;
	logic        sleep_event;
	logic        div_start;
	logic [15:0] rem_dbl;
	logic        tickle;
	logic        ms_tick;
	logic        wdt_expire;
	logic [1:0]  events;

	function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
		return a == {idx, 2'h0};
	endfunction
	// larger level means less gain, so the converter is not driven into clipping
	function automatic logic [1:0] gain_pick(input logic [1:0] level);
		return ~level;
	endfunction
	function automatic logic [24:0] sleep_limit(input logic [1:0] code);
		case (code)
			2'h0:    return 25'(SLEEP_CYC0);
			2'h1:    return 25'(SLEEP_CYC1);
			2'h2:    return 25'(SLEEP_CYC2);
			default: return 25'(SLEEP_CYC3);
		endcase
	endfunction
	function automatic logic [13:0] wdt_limit_ms(input logic src, input logic [1:0] p);
		case (p)
			2'h0:    return src ? `DCR_WDT_PIN_P0_MS : 14'(`DCR_WDT_BUS_P0_S * 1000);
			2'h1:    return src ? `DCR_WDT_PIN_P1_MS : 14'(`DCR_WDT_BUS_P1_S * 1000);
			2'h2:    return src ? `DCR_WDT_PIN_P2_MS : 14'(`DCR_WDT_BUS_P2_S * 1000);
			default: return src ? `DCR_WDT_PIN_P3_MS : 14'(`DCR_WDT_BUS_P3_S * 1000);
		endcase
	endfunction

	// apb decode: zero wait states, data and error prepared in the setup cycle
	assign setup     = psel && !penable;
	assign wr        = psel && penable && pwrite;
	assign hit_one   = hit(paddr, `DCR_IDX_SETUP_ONE);
	assign hit_two   = hit(paddr, `DCR_IDX_SETUP_TWO);
	assign hit_stat  = hit(paddr, `DCR_IDX_IRQ_STAT);
	assign hit_mask  = hit(paddr, `DCR_IDX_IRQ_MASK);
	assign hit_state = hit(paddr, `DCR_IDX_STATE);
	assign mapped    = hit_one || hit_two || hit_stat || hit_mask || hit_state;
	assign pready    = 1'b1;
	assign prdata    = prdata_q;
	assign pslverr   = pslverr_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (setup) begin
			pslverr_q <= !mapped;
			if (pwrite || !mapped)
				prdata_q <= 32'h0;
			else if (hit_one)
				prdata_q <= one_q & `DCR_ONE_WMASK;
			else if (hit_two)
				prdata_q <= two_q & `DCR_TWO_WMASK;
			else if (hit_stat)
				prdata_q <= {30'h0, stat_q};
			else if (hit_mask)
				prdata_q <= {30'h0, mask_q};
			else
				prdata_q <= {13'h0, wdt_latch_q, lowpower_q, div_q == dcr_pkg::DCR_DIV_RUN,
					duty_q};
		end
	end

	// address field resets to zero, then is taken from straps on the first clock after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			one_q        <= `DCR_ONE_RESET;
			strap_done_q <= 1'b0;
		end else begin
			strap_done_q <= 1'b1;
			if (!strap_done_q)
				one_q.target_addr <= target_addr_strap;
			else if (wr && hit_one && !pslverr_q)
				one_q <= pwdata & `DCR_ONE_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			two_q <= `DCR_TWO_RESET;
		else if (wr && hit_two && !pslverr_q)
			two_q <= pwdata & `DCR_TWO_WMASK;
	end

	// interrupt status: sticky, write one to clear, a new event beats the clear
	assign events = {wdt_expire, sleep_event};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= 2'h0;
			mask_q <= 2'h0;
		end else begin
			if (wr && hit_stat)
				stat_q <= (stat_q & ~pwdata[1:0]) | events;
			else
				stat_q <= stat_q | events;
			if (wr && hit_mask)
				mask_q <= pwdata[1:0];
		end
	end

	assign irq = |(stat_q & mask_q);
	// static steering straight from the setup bits
	assign analog_monitor_output_en = one_q.analog_monitor_output;
	assign shared_pin_route = 4'h1 << one_q.shared_pin_function_select;
	assign serial_target_addr       = one_q.target_addr;
	assign serial_pin_drive         = one_q.pin_drive;
	assign pullup_en                = one_q.pullup_on;
	assign max_supply_range_sel     = one_q.max_supply_range_sel;
	assign supply_range_reserved = one_q.max_supply_range_sel == `DCR_RANGE_RSV;
	assign lowpower_state_select    = two_q.lowpower_state_select;
	assign use_external_clock = two_q.clock_source == `DCR_CLK_EXTERNAL;
	assign clock_select_reserved = !use_external_clock
		&& two_q.clock_source != `DCR_CLK_INTERNAL;
	assign external_reference_mode_on  = two_q.external_reference_mode_on;
	assign external_reference_freq_sel = two_q.external_reference_freq_sel;

	// gains follow the measured level only when automatic adjustment is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cgain_q <= `DCR_GAIN_FIXED;
			vgain_q <= `DCR_GAIN_FIXED;
		end else begin
			cgain_q <= two_q.auto_current_gain_on ? gain_pick(current_level)
				: `DCR_GAIN_FIXED;
			vgain_q <= two_q.auto_voltage_gain_on ? gain_pick(voltage_level)
				: `DCR_GAIN_FIXED;
		end
	end
	assign current_gain_sel = cgain_q;
	assign voltage_gain_sel = vgain_q;
	// sleep entry timer; any sample above threshold restarts it
	assign sleep_event = rate_below_threshold && !lowpower_q
		&& sleep_cnt_q == sleep_limit(two_q.sleep_delay) - 25'h1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_cnt_q <= 25'h0;
			lowpower_q  <= 1'b0;
		end else if (!rate_below_threshold) begin
			sleep_cnt_q <= 25'h0;
			lowpower_q  <= 1'b0;
		end else if (sleep_event) begin
			lowpower_q <= 1'b1;
		end else if (!lowpower_q) begin
			sleep_cnt_q <= sleep_cnt_q + 25'h1;
		end
	end
	assign lowpower_req = lowpower_q;
	// duty = measured / full scale as Q1.15; one quotient bit per cycle saves a divider
	assign div_start = div_q == dcr_pkg::DCR_DIV_IDLE && freq_meas_valid
		&& input_ref_mode == `DCR_FREQ_MODE;
	assign rem_dbl = {rem_q[14:0], 1'b0};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q      <= dcr_pkg::DCR_DIV_IDLE;
			rem_q      <= 16'h0;
			quo_q      <= 15'h0;
			step_q     <= 4'h0;
			duty_q     <= 16'h0;
			duty_vld_q <= 1'b0;
		end else begin
			duty_vld_q <= 1'b0;
			case (div_q)
				dcr_pkg::DCR_DIV_IDLE: begin
					if (div_start) begin
						if (freq_meas >= two_q.full_scale_freq) begin
							duty_q     <= `DCR_DUTY_FULL;
							duty_vld_q <= 1'b1;
						end else begin
							rem_q  <= {1'b0, freq_meas};
							quo_q  <= 15'h0;
							step_q <= 4'h0;
							div_q  <= dcr_pkg::DCR_DIV_RUN;
						end
					end
				end
				dcr_pkg::DCR_DIV_RUN: begin
					if (rem_dbl >= {1'b0, two_q.full_scale_freq}) begin
						rem_q <= rem_dbl - {1'b0, two_q.full_scale_freq};
						quo_q <= {quo_q[13:0], 1'b1};
					end else begin
						rem_q <= rem_dbl;
						quo_q <= {quo_q[13:0], 1'b0};
					end
					step_q <= step_q + 4'h1;
					if (step_q == 4'he) begin
						duty_q     <= {1'b0, quo_q[13:0],
							rem_dbl >= {1'b0, two_q.full_scale_freq}};
						duty_vld_q <= 1'b1;
						div_q      <= dcr_pkg::DCR_DIV_IDLE;
					end
				end
				default: div_q <= dcr_pkg::DCR_DIV_IDLE;
			endcase
		end
	end
	assign duty_cmd       = duty_q;
	assign duty_cmd_valid = duty_vld_q;
	// host watchdog: millisecond prescaler, then a count of whole milliseconds
	assign tickle = two_q.host_watchdog_source ? (wdt_pin_tickle && !pin_prev_q)
		: wdt_bus_tickle;
	assign ms_tick = ms_pre_q == 17'(MS_CYC - 1);
	assign wdt_expire = two_q.host_watchdog_on && !tickle && ms_tick
		&& ms_cnt_q == wdt_limit_ms(two_q.host_watchdog_source,
			two_q.host_watchdog_period) - 14'h1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_q <= 1'b0;
			ms_pre_q   <= 17'h0;
			ms_cnt_q   <= 14'h0;
		end else begin
			pin_prev_q <= wdt_pin_tickle;
			if (!two_q.host_watchdog_on || tickle || ms_tick)
				ms_pre_q <= 17'h0;
			else
				ms_pre_q <= ms_pre_q + 17'h1;
			if (!two_q.host_watchdog_on || tickle || wdt_expire)
				ms_cnt_q <= 14'h0;
			else if (ms_tick)
				ms_cnt_q <= ms_cnt_q + 14'h1;
		end
	end

	// latched fault holds the bridge off until the watchdog is disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_latch_q <= 1'b0;
			wdt_rep_q   <= 1'b0;
		end else begin
			wdt_rep_q <= wdt_expire;
			if (wdt_expire && two_q.host_watchdog_action)
				wdt_latch_q <= 1'b1;
			else if (!two_q.host_watchdog_on)
				wdt_latch_q <= 1'b0;
		end
	end

	assign wdt_fault_report  = wdt_rep_q;
	assign wdt_fault_latched = wdt_latch_q;
	assign outputs_hiz       = wdt_latch_q;
	chk_mon_write: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_one && strap_done_q |=> analog_monitor_output_en == $past(pwdata[27])
			&& shared_pin_route == (4'h1 << $past(pwdata[29:28])))
		else $error("monitor setup not taken from write");
	chk_addr_strap: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(strap_done_q) |-> serial_target_addr == $past(target_addr_strap))
		else $error("target address not loaded from straps");
	chk_rsv_zero: assert property (@(posedge pclk) disable iff (!presetn)
		psel && penable && !pwrite && hit_one |-> (prdata & ~`DCR_ONE_WMASK) == 32'h0)
		else $error("reserved bits read nonzero");
	chk_range_code: assert property (@(posedge pclk) disable iff (!presetn)
		wr && hit_one && strap_done_q && pwdata[1:0] == 2'h3 |=> supply_range_reserved)
		else $error("reserved range code not flagged");
	chk_sleep_leave: assert property (@(posedge pclk) disable iff (!presetn)
		!rate_below_threshold |=> !lowpower_req)
		else $error("low power held with rate above threshold");
	chk_sleep_irq: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_event |=> lowpower_req && stat_q[`DCR_EV_SLEEP])
		else $error("sleep entry not flagged");
	chk_div_time: assert property (@(posedge pclk) disable iff (!presetn)
		div_start && freq_meas < two_q.full_scale_freq |-> ##16 duty_cmd_valid)
		else $error("duty not ready sixteen cycles after start");
	chk_freq_only: assert property (@(posedge pclk) disable iff (!presetn)
		input_ref_mode != 2'h3 && div_q == dcr_pkg::DCR_DIV_IDLE |=> !duty_cmd_valid)
		else $error("duty computed outside frequency mode");
	chk_wdt_latch: assert property (@(posedge pclk) disable iff (!presetn)
		wdt_expire && two_q.host_watchdog_action |=> outputs_hiz && wdt_fault_report)
		else $error("watchdog fault not latched");
	chk_wdt_report: assert property (@(posedge pclk) disable iff (!presetn)
		wdt_expire && !two_q.host_watchdog_action && !wdt_latch_q
			|=> !outputs_hiz && wdt_fault_report)
		else $error("report-only watchdog fault misbehaved");
	chk_gain_fixed: assert property (@(posedge pclk) disable iff (!presetn)
		!two_q.auto_current_gain_on |=> current_gain_sel == 2'h0)
		else $error("current gain moved while fixed");
	chk_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		sleep_event && wr && hit_stat && pwdata[0] |=> stat_q[0])
		else $error("event lost against clear");
	cov_sleep: cover property (@(posedge pclk) disable iff (!presetn) sleep_event);
	cov_wdt_hiz: cover property (@(posedge pclk) disable iff (!presetn) $rose(outputs_hiz));
	cov_duty: cover property (@(posedge pclk) disable iff (!presetn)
		duty_cmd_valid && !duty_cmd[15]);
endmodule

/* File: rtl/dcr_cfg.svh */
// offsets, field positions, reset values and timing figures of the setup bank
`ifndef DCR_CFG_SVH
`define DCR_CFG_SVH
`define DCR_IDX_SETUP_ONE 8'ha6
`define DCR_IDX_SETUP_TWO 8'ha8
`define DCR_IDX_IRQ_STAT  8'hb0
`define DCR_IDX_IRQ_MASK  8'hb1
`define DCR_IDX_STATE     8'hb2
`define DCR_ONE_WMASK     32'h3ff0001f
`define DCR_TWO_WMASK     32'h7fffffff
`define DCR_ONE_RESET     32'h00000000
`define DCR_TWO_RESET     32'h00000000
`define DCR_EV_SLEEP      0
`define DCR_EV_WDT        1
`define DCR_FREQ_MODE     2'h3
`define DCR_CLK_EXTERNAL  2'h3
`define DCR_CLK_INTERNAL  2'h0
`define DCR_RANGE_RSV     2'h3
`define DCR_GAIN_FIXED    2'h0
`define DCR_DUTY_FULL     16'h8000
`define DCR_CLK_PERIOD_NS 10
`define DCR_SLEEP_T0_US   50
`define DCR_SLEEP_T1_US   200
`define DCR_SLEEP_T2_MS   20
`define DCR_SLEEP_T3_MS   200
`define DCR_WDT_PIN_P0_MS 14'd100
`define DCR_WDT_PIN_P1_MS 14'd200
`define DCR_WDT_PIN_P2_MS 14'd500
`define DCR_WDT_PIN_P3_MS 14'd1000
`define DCR_WDT_BUS_P0_S  14'd1
`define DCR_WDT_BUS_P1_S  14'd2
`define DCR_WDT_BUS_P2_S  14'd3
`define DCR_WDT_BUS_P3_S  14'd10
`endif

/* File: rtl/dcr_pkg.sv */
// types of the device setup register bank
package dcr_pkg;
	typedef struct packed {
		logic [1:0]  rsv_hi;
		logic [1:0]  shared_pin_function_select;
		logic        analog_monitor_output;
		logic [6:0]  target_addr;
		logic [14:0] rsv_mid;
		logic [1:0]  pin_drive;
		logic        pullup_on;
		logic [1:0]  max_supply_range_sel;
	} dcr_one_t;

	typedef struct packed {
		logic        rsv_hi;
		logic [14:0] full_scale_freq;
		logic [1:0]  sleep_delay;
		logic        auto_current_gain_on;
		logic        auto_voltage_gain_on;
		logic        lowpower_state_select;
		logic [1:0]  clock_source;
		logic        external_reference_mode_on;
		logic [2:0]  external_reference_freq_sel;
		logic        host_watchdog_on;
		logic [1:0]  host_watchdog_period;
		logic        host_watchdog_source;
		logic        host_watchdog_action;
	} dcr_two_t;

	typedef enum logic {DCR_DIV_IDLE, DCR_DIV_RUN} dcr_div_state_t;
endpackage

/* File: tb/dcr_host_model.sv */
// host-side model that tickles the device watchdog over the bus or the pin
`timescale 1ns/1ps
module dcr_host_model #(
	parameter int TICK_CYC = 200
) (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// control from the bench
	input  wire logic tick_on,
	input  wire logic tick_pin,
	// tickles towards the device
	output logic      wdt_bus_tickle,
	output logic      wdt_pin_tickle
);
	int cnt_q;

	// the period stays well inside the shortest watchdog window
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			wdt_bus_tickle <= 1'b0;
			wdt_pin_tickle <= 1'b0;
		end else if (!tick_on) begin
			cnt_q <= 0;
			wdt_bus_tickle <= 1'b0;
			wdt_pin_tickle <= 1'b0;
		end else begin
			cnt_q <= (cnt_q == TICK_CYC - 1) ? 0 : cnt_q + 1;
			wdt_bus_tickle <= !tick_pin && cnt_q == TICK_CYC - 1;
			// pin held high a few cycles so only one rising edge per period
			wdt_pin_tickle <= tick_pin && cnt_q < 4;
		end
	end
endmodule

/* File: tb/test_dcr_device_setup.sv */
// self-checking bench of the device setup register bank
`timescale 1ns/1ps
module test_dcr_device_setup;
	localparam logic [9:0] A_ONE  = 10'h298;
	localparam logic [9:0] A_TWO  = 10'h2a0;
	localparam logic [9:0] A_STAT = 10'h2c0;
	localparam logic [9:0] A_MASK = 10'h2c4;
	localparam int         SLP [4] = '{4, 8, 16, 32};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [6:0]  strap = 7'h00;
	logic [1:0]  ref_mode = 2'h0, cur_lvl = 2'h0, volt_lvl = 2'h0;
	logic        f_valid = 1'b0, below = 1'b0, tick_on = 1'b0, tick_pin = 1'b0;
	logic [14:0] f_meas = 15'h0000;
	logic [31:0] prdata, rd;
	logic [15:0] duty;
	logic [6:0]  t_addr;
	logic [3:0]  route;
	logic [2:0]  ref_sel;
	logic [1:0]  drive, rng, cgain, vgain;
	logic        pready, pslverr, mon_en, bus_tk, pin_tk, pull, rng_rsv, d_valid, err;
	logic        lp_req, lp_sel, ext_clk, clk_rsv, ref_on, rep, latched, hiz, irq;
	int          miscompares = 0;
	int          checks = 0;
	int          valid_n = 0;
	int          rep_n = 0;

	dcr_device_setup #(.SLEEP_CYC0(SLP[0]), .SLEEP_CYC1(SLP[1]), .SLEEP_CYC2(SLP[2]),
		.SLEEP_CYC3(SLP[3]), .MS_CYC(10)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.target_addr_strap(strap), .input_ref_mode(ref_mode), .freq_meas_valid(f_valid),
		.freq_meas(f_meas), .rate_below_threshold(below), .current_level(cur_lvl),
		.voltage_level(volt_lvl), .wdt_bus_tickle(bus_tk), .wdt_pin_tickle(pin_tk),
		.analog_monitor_output_en(mon_en), .shared_pin_route(route),
		.serial_target_addr(t_addr), .serial_pin_drive(drive), .pullup_en(pull),
		.max_supply_range_sel(rng), .supply_range_reserved(rng_rsv), .duty_cmd(duty),
		.duty_cmd_valid(d_valid), .lowpower_req(lp_req), .lowpower_state_select(lp_sel),
		.current_gain_sel(cgain), .voltage_gain_sel(vgain), .use_external_clock(ext_clk),
		.clock_select_reserved(clk_rsv), .external_reference_mode_on(ref_on),
		.external_reference_freq_sel(ref_sel), .wdt_fault_report(rep),
		.wdt_fault_latched(latched), .outputs_hiz(hiz), .irq(irq));

	dcr_host_model #(.TICK_CYC(200)) host (.pclk(pclk), .presetn(presetn), .tick_on(tick_on),
		.tick_pin(tick_pin), .wdt_bus_tickle(bus_tk), .wdt_pin_tickle(pin_tk));

	always #5 pclk = ~pclk;

	always @(posedge pclk) begin
		if (d_valid === 1'b1) valid_n++;
		if (rep === 1'b1) rep_n++;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// divide rounds down; any measurement at or above full scale is 100 percent
	function automatic logic [15:0] exp_duty(input logic [14:0] f, input logic [14:0] fs);
		if (f >= fs) return 16'h8000;
		return 16'(({17'h00000, f} << 15) / fs);
	endfunction

	task automatic print_verdict;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		#800000;
		miscompares++;
		print_verdict();
	end

	initial begin
		int i, k, n;
		logic [31:0] v, e;
		logic [17:0] x;
		logic [14:0] f, fs;
		void'($urandom(35));
		strap <= 7'($urandom);
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, A_ONE, 32'h00000000);
		chk("one reset", {5'h00, strap, 20'h00000}, rd);
		apb(1'b0, A_TWO, 32'h00000000);
		chk("two reset", 32'h00000000, rd);
		chk("route reset", 32'h00000001, 32'(route));
		apb(1'b0, 10'h29c, 32'h00000000);
		chk("unmapped", 32'h00000001, 32'(err));
		$display("test reset done");
		for (i = 0; i < 8; i++) begin
			v = $urandom;
			v[1:0] = 2'(i);
			apb(1'b1, A_ONE, v);
			apb(1'b0, A_ONE, 32'h00000000);
			e = v & 32'h3ff0001f;
			chk("one readback", e, rd);
			x = {e[27], 4'h1 << e[29:28], e[26:20], e[4:0], e[1:0] == 2'h3};
			v = 32'({mon_en, route, t_addr, drive, pull, rng, rng_rsv});
			chk("one pins", 32'(x), v);
			v = $urandom;
			v[10:9] = 2'(i);
			v[4] = 1'b0;
			cur_lvl <= 2'($urandom);
			volt_lvl <= 2'($urandom);
			apb(1'b1, A_TWO, v);
			apb(1'b0, A_TWO, 32'h00000000);
			e = v & 32'h7fffffff;
			chk("two readback", e, rd);
			x = 18'({e[10:9] == 2'h3, e[10:9] == 2'h1 || e[10:9] == 2'h2, e[8], e[7:5], e[11]});
			chk("two pins", 32'(x), 32'({ext_clk, clk_rsv, ref_on, ref_sel, lp_sel}));
			x = 18'({e[13] ? ~cur_lvl : 2'h0, e[12] ? ~volt_lvl : 2'h0});
			chk("gains", 32'(x), 32'({cgain, vgain}));
		end
		$display("test setup done");
		ref_mode <= 2'h3;
		for (i = 0; i < 6; i++) begin
			fs = (i == 0) ? 15'h7fff : (i == 5) ? 15'h0000 : 15'($urandom) | 15'h0001;
			f = (i == 4) ? fs : 15'($urandom % (fs | 15'h0001));
			apb(1'b1, A_TWO, {1'b0, fs, 16'h0000});
			@(posedge pclk);
			f_meas <= f;
			f_valid <= 1'b1;
			@(posedge pclk);
			f_valid <= 1'b0;
			for (k = 0; k < 40 && d_valid !== 1'b1; k++) @(posedge pclk);
			chk("duty", 32'(exp_duty(f, fs)), 32'(duty));
		end
		// let the last duty pulse be counted before the baseline is taken
		@(posedge pclk);
		for (i = 0; i < 3; i++) begin
			n = valid_n;
			ref_mode <= 2'(i);
			f_valid <= 1'b1;
			@(posedge pclk);
			f_valid <= 1'b0;
			repeat (30) @(posedge pclk);
			chk("mode refused", n, valid_n);
		end
		$display("test duty done");
		for (i = 0; i < 4; i++) begin
			apb(1'b1, A_MASK, (i == 0) ? 32'h00000000 : 32'h00000003);
			apb(1'b1, A_TWO, {16'h0000, 2'(i), 14'h0000});
			below <= 1'b1;
			for (k = 0; k < 100 && lp_req !== 1'b1; k++) @(posedge pclk);
			chk("sleep delay", 32'h1, 32'(k >= SLP[i] && k <= SLP[i] + 3));
			@(posedge pclk);
			chk("irq mask", 32'(i != 0), 32'(irq));
			apb(1'b0, A_STAT, 32'h00000000);
			chk("status sleep", 32'h1, 32'(rd[0]));
			below <= 1'b0;
			apb(1'b1, A_STAT, 32'h00000001);
			repeat (2) @(posedge pclk);
			chk("lowpower off", 32'h0, 32'({lp_req, irq}));
		end
		// clear and sleep entry on one edge: the entry must survive the clear
		apb(1'b1, A_TWO, 32'h00000000);
		below <= 1'b1;
		@(posedge pclk);
		apb(1'b1, A_STAT, 32'h00000001);
		apb(1'b0, A_STAT, 32'h00000000);
		chk("set wins", 32'h1, 32'(rd[0]));
		below <= 1'b0;
		apb(1'b1, A_STAT, 32'h00000001);
		$display("test sleep done");
		apb(1'b1, A_TWO, 32'h00000013);
		tick_pin <= 1'b1;
		tick_on <= 1'b1;
		repeat (3000) @(posedge pclk);
		chk("pin kept", 0, rep_n);
		// bus tickles now, which the pin source must ignore
		tick_pin <= 1'b0;
		repeat (700) @(posedge pclk);
		chk("early latch", 32'h0, 32'(latched));
		for (k = 0; k < 400 && latched !== 1'b1; k++) @(posedge pclk);
		chk("latch hiz", 32'h3, 32'({latched, hiz}));
		tick_on <= 1'b0;
		apb(1'b1, A_TWO, 32'h00000000);
		repeat (2) @(posedge pclk);
		chk("latch clear", 32'h0, 32'(latched));
		apb(1'b1, A_STAT, 32'h00000002);
		n = rep_n;
		apb(1'b1, A_TWO, 32'h00000010);
		tick_on <= 1'b1;
		repeat (12000) @(posedge pclk);
		chk("bus kept", n, rep_n);
		tick_on <= 1'b0;
		repeat (10100) @(posedge pclk);
		chk("report only", n + 1, rep_n);
		chk("no latch", 32'h0, 32'(latched));
		apb(1'b0, A_STAT, 32'h00000000);
		chk("status wdt", 32'h1, 32'(rd[1]));
		$display("test watchdog done");
		print_verdict();
	end
endmodule
